// File: i2civ_pkg.sv
/*
  constants for the two-wire controller interrupt flag and vector block:
  register offsets, flag bit positions, reset values, vector codes and
  the priority order of the sources.
  assumes a 32-bit axi4-lite register bus with word-aligned registers.
*/
//
// Functional notes
// - addr3 tx flag bit 13, resets one
// - addr2 tx flag bit 11 on slave empty
// - addr1 tx flag bit 9, resets one
// - addr1 rx flag bit 8 on byte
// - addr2 rx bit 10, addr3 rx bit 12
// - primary tx bit 1: master or addr0
// - primary rx bit 0: master or addr0
// - no-ack flag bit 5 only in master
// - arb lost 4, stop 3, start 2
// - timeout 7, byte count 6, ninth bit 14
// - flags read pending, software may write them
// - 16-bit read-only vector, zero when idle
// - arb lost 02h, no-ack 04h, start 06h
// - stop 08h, addr3 rx 0Ah
// - addr3 tx 0Ch, addr2 rx 0Eh, tx 10h
// - addr1 rx 12h, addr1 tx 14h
// - primary rx 16h, primary tx 18h
// - byte count 1Ah, timeout 1Ch, ninth 1Eh
// - vector write clears all flags
// - vector is even jump-table offset
// - flag counts only when enable bit set
`default_nettype none

package i2civ_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // register byte offsets
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_VECTOR = 8'h08;

  // flag bit positions
  localparam int unsigned BIT_RX0   = 0;
  localparam int unsigned BIT_TX0   = 1;
  localparam int unsigned BIT_START = 2;
  localparam int unsigned BIT_STOP  = 3;
  localparam int unsigned BIT_ARB   = 4;
  localparam int unsigned BIT_NACK  = 5;
  localparam int unsigned BIT_BCNT  = 6;
  localparam int unsigned BIT_CLTO  = 7;
  localparam int unsigned BIT_RX1   = 8;
  localparam int unsigned BIT_TX1   = 9;
  localparam int unsigned BIT_RX2   = 10;
  localparam int unsigned BIT_TX2   = 11;
  localparam int unsigned BIT_RX3   = 12;
  localparam int unsigned BIT_TX3   = 13;
  localparam int unsigned BIT_NINTH = 14;

  // bit 15 is reserved and reads zero
  localparam logic [15:0] FLAG_MASK   = 16'h7FFF;
  localparam logic [15:0] FLAG_RESET  = 16'h2200;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] VECTOR_NONE = 16'h0000;

  // sources from highest to lowest priority; the code of entry i is 2*(i+1)
  localparam int unsigned NUM_SRC = 15;
  localparam logic [3:0] PRIO_BIT [0:NUM_SRC-1] = '{
    4'h4, 4'h5, 4'h2, 4'h3, 4'hC, 4'hD, 4'hA, 4'hB,
    4'h8, 4'h9, 4'h0, 4'h1, 4'h6, 4'h7, 4'hE
  };

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : i2civ_pkg

`default_nettype wire

// File: i2civ_flags_vector.sv
/*
  interrupt flag register, enable register and prioritised vector of a
  two-wire bus controller, reached over an axi4-lite slave port.
  assumes the bus engine drives one-cycle event strobes synchronous to
  aclk, and a frame_match level telling which own address hit this frame.
*/
`default_nettype none

module i2civ_flags_vector #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                is_master,
  input  wire logic [3:0]          frame_match,
  input  wire logic                tx_empty_ev,
  input  wire logic                rx_byte_ev,
  input  wire logic                start_ev,
  input  wire logic                stop_ev,
  input  wire logic                arb_lost_ev,
  input  wire logic                nack_ev,
  input  wire logic                byte_count_ev,
  input  wire logic                clock_low_timeout_ev,
  input  wire logic                ninth_bit_ev,
  output logic                     irq_request,
  output logic [15:0]              vector_value
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must be 4..32");
  end

  typedef struct packed {
    logic [15:0]       flags;
    logic [15:0]       enable;
    logic [15:0]       vector;
    logic              irq;
    logic              aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } i2civ_state_t;

  i2civ_state_t state_reg;
  i2civ_state_t state_next;

  // highest-priority pending and enabled source, as code and flag index
  function automatic logic [19:0] i2civ_pick(input logic [15:0] pend);
    logic [19:0] res;
    res = {4'h0, i2civ_pkg::VECTOR_NONE};
    for (int i = i2civ_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i2civ_pkg::PRIO_BIT[i]]) begin
        res = {i2civ_pkg::PRIO_BIT[i], 16'((i + 1) * 2)};
      end
    end
    return res;
  endfunction : i2civ_pick

  function automatic logic [15:0] i2civ_merge(input logic [15:0] old_v,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res & i2civ_pkg::FLAG_MASK;
  endfunction : i2civ_merge

  logic [15:0] pending;
  logic [19:0] pick_now;
  logic [15:0] hw_set;

  // the codes to follow from the priority table
  assign pending  = state_reg.flags & state_reg.enable;
  assign pick_now = i2civ_pick(pending);

  always_comb begin
    hw_set = 16'h0000;
    hw_set[i2civ_pkg::BIT_TX3]   = tx_empty_ev & ~is_master & frame_match[3];
    hw_set[i2civ_pkg::BIT_TX2]   = tx_empty_ev & ~is_master & frame_match[2];
    hw_set[i2civ_pkg::BIT_TX1]   = tx_empty_ev & ~is_master & frame_match[1];
    hw_set[i2civ_pkg::BIT_RX1]   = rx_byte_ev & ~is_master & frame_match[1];
    hw_set[i2civ_pkg::BIT_RX2]   = rx_byte_ev & ~is_master & frame_match[2];
    hw_set[i2civ_pkg::BIT_RX3]   = rx_byte_ev & ~is_master & frame_match[3];
    hw_set[i2civ_pkg::BIT_TX0]   = tx_empty_ev & (is_master | frame_match[0]);
    hw_set[i2civ_pkg::BIT_RX0]   = rx_byte_ev & (is_master | frame_match[0]);
    hw_set[i2civ_pkg::BIT_NACK]  = nack_ev & is_master;
    hw_set[i2civ_pkg::BIT_ARB]   = arb_lost_ev;
    hw_set[i2civ_pkg::BIT_STOP]  = stop_ev;
    hw_set[i2civ_pkg::BIT_START] = start_ev;
    hw_set[i2civ_pkg::BIT_CLTO]  = clock_low_timeout_ev;
    hw_set[i2civ_pkg::BIT_BCNT]  = byte_count_ev;
    hw_set[i2civ_pkg::BIT_NINTH] = ninth_bit_ev;
  end

  always_comb begin
    logic              aw_ok;
    logic              w_ok;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wdat;
    logic [3:0]        wstb;
    logic [7:0]        woff;
    logic [7:0]        roff;
    logic [15:0]       flags_v;
    logic [19:0]       pick_v;
    aw_ok   = 1'b0;
    w_ok    = 1'b0;
    waddr   = state_reg.awaddr;
    wdat    = state_reg.wdata;
    wstb    = state_reg.wstrb;
    woff    = 8'h00;
    roff    = 8'h00;
    flags_v = state_reg.flags;
    pick_v  = 20'h00000;
    state_next = state_reg;

    // response channels retire on their handshake
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // address and data may arrive in either order; hold each until both are in
    aw_ok = state_reg.aw_have | (s_axi_awvalid & s_axi_awready);
    w_ok  = state_reg.w_have | (s_axi_wvalid & s_axi_wready);
    if (!state_reg.aw_have) begin
      waddr = s_axi_awaddr;
    end
    if (!state_reg.w_have) begin
      wdat = s_axi_wdata;
      wstb = s_axi_wstrb;
    end
    state_next.aw_have = aw_ok;
    state_next.awaddr  = waddr;
    state_next.w_have  = w_ok;
    state_next.wdata   = wdat;
    state_next.wstrb   = wstb;

    if (aw_ok && w_ok && !state_reg.bvalid) begin
      state_next.aw_have = 1'b0;
      state_next.w_have  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = i2civ_pkg::RESP_OKAY;
      woff = {waddr[7:2], 2'b00};
      if (ADDR_W > 8 && (waddr >> 8) != '0) begin
        state_next.bresp = i2civ_pkg::RESP_SLVERR;
      end else if (woff == i2civ_pkg::OFS_FLAGS) begin
        flags_v = i2civ_merge(flags_v, wdat, wstb);
      end else if (woff == i2civ_pkg::OFS_ENABLE) begin
        state_next.enable = i2civ_merge(state_reg.enable, wdat, wstb);
      end else if (woff == i2civ_pkg::OFS_VECTOR) begin
        // any write, whatever its strobes, empties the flags
        flags_v = 16'h0000;
      end else begin
        state_next.bresp = i2civ_pkg::RESP_SLVERR;
      end
    end

    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = i2civ_pkg::RESP_OKAY;
      state_next.rdata  = 32'h00000000;
      roff = {s_axi_araddr[7:2], 2'b00};
      if (ADDR_W > 8 && (s_axi_araddr >> 8) != '0) begin
        state_next.rresp = i2civ_pkg::RESP_SLVERR;
      end else if (roff == i2civ_pkg::OFS_FLAGS) begin
        state_next.rdata = {16'h0000, state_reg.flags};
      end else if (roff == i2civ_pkg::OFS_ENABLE) begin
        state_next.rdata = {16'h0000, state_reg.enable};
      end else if (roff == i2civ_pkg::OFS_VECTOR) begin
        state_next.rdata = {16'h0000, pick_now[15:0]};
        if (pick_now[15:0] != i2civ_pkg::VECTOR_NONE) begin
          flags_v[pick_now[19:16]] = 1'b0;
        end
      end else begin
        state_next.rresp = i2civ_pkg::RESP_SLVERR;
      end
    end

    // events of this cycle win over any clear of the same cycle
    flags_v = (flags_v | hw_set) & i2civ_pkg::FLAG_MASK;
    state_next.flags = flags_v;

    // irq and vector are registered on the same edge as the flags they follow
    pick_v = i2civ_pick(flags_v & state_next.enable);
    state_next.vector = pick_v[15:0];
    state_next.irq    = (flags_v & state_next.enable) != 16'h0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg        <= '0;
      state_reg.flags  <= i2civ_pkg::FLAG_RESET;
      state_reg.enable <= i2civ_pkg::ENABLE_RESET;
      state_reg.vector <= i2civ_pkg::VECTOR_NONE;
      state_reg.bresp  <= i2civ_pkg::RESP_OKAY;
      state_reg.rresp  <= i2civ_pkg::RESP_OKAY;
    end else begin
      state_reg <= state_next;
    end
  end

  // one write and one read in flight; ready drops while a response waits
  assign s_axi_awready = ~state_reg.aw_have & ~state_reg.bvalid;
  assign s_axi_wready  = ~state_reg.w_have & ~state_reg.bvalid;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = ~state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;
  assign irq_request   = state_reg.irq;
  assign vector_value  = state_reg.vector;

endmodule : i2civ_flags_vector

`default_nettype wire

// File: i2civ_flags_vector_properties.sv
/*
  checker for the flag and vector block: bus timing and vector shape.
  assumes one clock aclk and a synchronous active-low aresetn.
*/
`default_nettype none
module i2civ_props #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq_request,
  input wire logic [15:0] vector_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_LAT: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_NO_AW_B: assert property (!(s_axi_bvalid && s_axi_awready))
    else $error("write address taken during response");
  AST_R_LAT: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_AR_RDY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_IRQ_VEC: assert property (irq_request == (vector_value != 16'h0000))
    else $error("request and vector disagree");
  AST_VEC_EVEN: assert property (!vector_value[0] && vector_value <= 16'h001E)
    else $error("vector code out of set");
endmodule : i2civ_props
bind i2civ_flags_vector i2civ_props #(.ADDR_W(ADDR_W)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .irq_request(irq_request), .vector_value(vector_value));
`default_nettype wire

// File: i2civ_engine_model.sv
/*
  bus engine stand-in: turns bench requests into one-cycle event strobes.
  assumes requests are held for exactly one aclk cycle.
*/
`default_nettype none
module i2civ_engine_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       mode_mst,
  input  wire logic [3:0] match,
  input  wire logic [8:0] ev_req,
  output var  logic       is_master = 1'b0,
  output var  logic [3:0] frame_match = 4'h0,
  output var  logic [8:0] ev = 9'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode and match move with the strobe so no event sees a stale frame
  always @(posedge aclk) begin
    is_master   <= aresetn & mode_mst;
    frame_match <= aresetn ? match : 4'h0;
    ev          <= aresetn ? ev_req : 9'h000;
  end
endmodule : i2civ_engine_model
`default_nettype wire

// File: testbench.sv
/*
  bench for the flag and vector block: register tests over axi4-lite.
  assumes the engine model and the bound checker are compiled first.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        arvalid, arready, rvalid, is_master, irq_request, mode_mst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  frame_match, match;
  logic [8:0]  ev, ev_req;
  logic [15:0] vector_value, d;
  logic [23:0] t;
  int          bad_count, tests_run, n_wait;
  // event, master, match, flag bit, vector code
  localparam logic [23:0] TBL [15] = '{24'h110016, 24'h001118, 24'h200206, 24'h300308,
    24'h400402, 24'h510504, 24'h60061A, 24'h70071C, 24'h102812, 24'h002914,
    24'h104A0E, 24'h004B10, 24'h108C0A, 24'h008D0C, 24'h800E1E};
  i2civ_flags_vector #(.ADDR_W(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .is_master(is_master), .frame_match(frame_match), .tx_empty_ev(ev[0]),
    .rx_byte_ev(ev[1]), .start_ev(ev[2]), .stop_ev(ev[3]), .arb_lost_ev(ev[4]),
    .nack_ev(ev[5]), .byte_count_ev(ev[6]), .clock_low_timeout_ev(ev[7]),
    .ninth_bit_ev(ev[8]), .irq_request(irq_request), .vector_value(vector_value));
  i2civ_engine_model engine (.aclk(aclk), .aresetn(aresetn), .mode_mst(mode_mst),
    .match(match), .ev_req(ev_req), .is_master(is_master), .frame_match(frame_match), .ev(ev));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic step();
    @(posedge aclk);
    n_wait++;
    if (n_wait > 100) begin
      bad_count++;
      report_and_stop();
    end
  endtask : step
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // address and data go out together; either may be taken first
  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n_wait = 0;
    awaddr <= a;
    wdata <= {16'h0000, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      step();
      aw_ok |= awready;
      w_ok |= wready;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!(aw_ok && w_ok));
    do step(); while (!bvalid);
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    n_wait = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do step(); while (!arready);
    arvalid <= 1'b0;
    do step(); while (!rvalid);
    d = rdata[15:0];
    resp = rresp;
  endtask : rd
  task automatic pulse(input logic [3:0] e, input logic m, input logic [3:0] mt);
    mode_mst <= m;
    match <= mt;
    ev_req <= 9'h001 << e;
    @(posedge aclk);
    ev_req <= 9'h000;
    repeat (3) @(posedge aclk);
  endtask : pulse
  initial begin
    {aresetn, awvalid, wvalid, arvalid, mode_mst} = 5'h00;
    {awaddr, araddr, wdata, match, ev_req} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(i2civ_pkg::OFS_FLAGS);
    check(d, 16'h2200);
    rd(i2civ_pkg::OFS_ENABLE);
    check(d, 16'h0000);
    rd(i2civ_pkg::OFS_VECTOR);
    check(d, 16'h0000);
    $display("reset test done");
    wr(i2civ_pkg::OFS_ENABLE, 16'h7FFF);
    for (int i = 0; i < 15; i++) begin
      t = TBL[i];
      wr(i2civ_pkg::OFS_FLAGS, 16'h0000);
      pulse(t[23:20], t[16], t[15:12]);
      rd(i2civ_pkg::OFS_FLAGS);
      check(d, 16'h0001 << t[11:8]);
      rd(i2civ_pkg::OFS_VECTOR);
      check(d, {8'h00, t[7:0]});
      rd(i2civ_pkg::OFS_FLAGS);
      check(d, 16'h0000);
    end
    pulse(4'h5, 1'b0, 4'h0);
    rd(i2civ_pkg::OFS_FLAGS);
    check(d, 16'h0000);
    pulse(4'h0, 1'b1, 4'h2);
    rd(i2civ_pkg::OFS_FLAGS);
    check(d, 16'h0002);
    $display("event test done");
    wr(i2civ_pkg::OFS_FLAGS, 16'hFFFF);
    rd(i2civ_pkg::OFS_FLAGS);
    check(d, 16'h7FFF);
    for (int i = 1; i <= 16; i++) begin
      rd(i2civ_pkg::OFS_VECTOR);
      check(d, (i == 16) ? 16'h0000 : 16'(2 * i));
    end
    $display("priority test done");
    wr(i2civ_pkg::OFS_ENABLE, 16'h7FEF);
    wr(i2civ_pkg::OFS_FLAGS, 16'h0010);
    rd(i2civ_pkg::OFS_VECTOR);
    check(d, 16'h0000);
    check({15'h0000, irq_request}, 16'h0000);
    wr(i2civ_pkg::OFS_ENABLE, 16'h0010);
    rd(i2civ_pkg::OFS_VECTOR);
    check(d, 16'h0002);
    $display("enable test done");
    wr(i2civ_pkg::OFS_FLAGS, 16'h7FFF);
    wr(i2civ_pkg::OFS_VECTOR, 16'h1234);
    rd(i2civ_pkg::OFS_FLAGS);
    check(d, 16'h0000);
    rd(i2civ_pkg::OFS_VECTOR);
    check(d, 16'h0000);
    $display("vector write test done");
    wr(8'h0C, 16'hFFFF);
    check({14'h0000, resp}, 16'h0002);
    rd(8'h0C);
    check({14'h0000, resp}, 16'h0002);
    check(d, 16'h0000);
    $display("unmapped test done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
